// ==== verilog/chan_adapter_pkg.sv ====
`default_nettype none
package chan_adapter_pkg;

  // ==========================================================
  // Configuration register offsets
  localparam logic [15:0] OFF_ID_LOW = 16'h0100;
  localparam logic [15:0] OFF_ID_HIGH = 16'h0101;
  localparam logic [15:0] OFF_CONTROL = 16'h0102;
  localparam logic [15:0] OFF_PRIM_LOW = 16'h0103;
  localparam logic [15:0] OFF_PRIM_HIGH = 16'h0104;
  localparam logic [15:0] OFF_SEC_BITS = 16'h0105;

  // ==========================================================
  // Control register fields
  localparam int CTL_CARD_EN_BIT = 0;
  localparam int CTL_OUT_LSB = 1;
  localparam int CTL_SEC_DIS_BIT = 5;
  localparam int CTL_SADR14_BIT = 6;
  localparam int CTL_SADR15_BIT = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] ADDR_REG_RESET = 8'h00;
  localparam logic [1:0] SEC_UNUSED_ONES = 2'h3;

  // ==========================================================
  // Wait timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int WS1_MIN_NS = 210;
  localparam int WS1_MAX_NS = 290;
  localparam int WS2_MIN_NS = 420;
  localparam int WS2_MAX_NS = 500;
  localparam int SYNC_EXT_NS = 40;
  // Aim at the middle of each window
  localparam int WS1_CYCLES = ((WS1_MIN_NS + WS1_MAX_NS) / 2) / CLK_PERIOD_NS;
  localparam int WS2_CYCLES = ((WS2_MIN_NS + WS2_MAX_NS) / 2) / CLK_PERIOD_NS;
  localparam int SYNC_CYCLES = (SYNC_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_CNT_W = 6;

  typedef enum logic [1:0] {
    MODE_SYNC_EXT,
    MODE_WAIT1,
    MODE_WAIT2,
    MODE_ASYNC_EXT
  } wait_mode_e;

  typedef enum {
    RDY_IDLE,
    RDY_DECODED,
    RDY_COUNT,
    RDY_WAIT_SLOW,
    RDY_DONE
  } rdy_state_e;

  // Channel status carried together
  typedef struct packed {
    logic mem_io;
    logic s0;
    logic s1;
  } chan_status_s;

  typedef struct packed {
    logic io_read;
    logic io_write;
  } cycle_kind_s;

endpackage
`default_nettype wire

// ==== verilog/channel_io_slave_adapter.sv ====
// Operation
// - Wait-select pins pick sync, wait 1, wait 2 or async extension.
// - Setup read of low ID register drives the low ID strobe high.
// - Setup read of high ID register activates the high ID strobe.
// - Outside setup, primary select goes low on a primary address match.
// - Secondary select low only on secondary match with control bit 5 zero.
// - Config registers reachable only with setup low, IO cycle, read or write.
// - Both ID registers read-only, returning the eight ID pins, bit 0 LSB.
// - Control bits: enable, four outputs, secondary disable, secondary bits 14-15.
// - Control register read/write, cleared to zero by reset.
// - Primary address bits 15-2 in 103/104; 103 bits 1,0 hold secondary 8,3.
// - Register 105 holds secondary 13,12,7-4; bits 7,6 read one.
// - Unstored secondary bits 11-9 and 2 borrow primary bits.
// - Control bit 5 zero enables secondary relocation, one disables it.
// - Compare bits 15-4 always, 3 and 2 unless masked, never 1-0.
// - Peripheral read/write strobes only on a match, gated by command.
// - Card select feedback on peripheral address, inactive in setup.
// - Setup cycles keep channel ready active, no waits.
// - Every matched normal IO access is extended by dropping ready.
// - Sync mode: ready low at decode, released shortly after command.
// - Wait 1: ready low 210-290 ns from command active.
// - Wait 2: ready low 420-500 ns from command active.
// - Async mode: ready low until a rising edge on slow ready.
// - Wait states timed by counting system clock cycles.
// - Buffer enable on any access to us; direction only for reads.
`timescale 1ns/100ps
`default_nettype none
module channel_io_slave_adapter
  import chan_adapter_pkg::*;
#(
  parameter int WS1_COUNT = WS1_CYCLES,
  parameter int WS2_COUNT = WS2_CYCLES,
  parameter int SYNC_COUNT = SYNC_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [15:0] host_addr,
  input wire chan_status_s host_status,
  input wire logic cmd_n,
  input wire logic adl_n,
  input wire logic card_setup_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] card_id_pins,
  input wire logic compare_bypass_bit2_n,
  input wire logic compare_bypass_bit3_n,
  input wire logic wait_select_hi,
  input wire logic wait_select_lo,
  input wire logic slow_ready_input,
  output logic id_low_strobe,
  output logic id_high_strobe,
  output logic [3:0] latched_addr,
  output logic card_enable_output,
  output logic [3:0] config_outputs,
  output logic periph_read_strobe_n,
  output logic periph_write_strobe_n,
  output logic card_select_feedback_n,
  output logic channel_ready_out,
  output logic buffer_enable_n,
  output logic buffer_direction_n
);

  // ==========================================================
  // Helpers
  function automatic cycle_kind_s decode_kind(input chan_status_s st);
    cycle_kind_s k;
    k.io_write = !st.mem_io && !st.s0 && st.s1;
    k.io_read = !st.mem_io && st.s0 && !st.s1;
    return k;
  endfunction

  function automatic logic reloc_match(input logic [15:0] a, input logic [15:2] r,
                                       input logic m3_n, input logic m2_n);
    logic hit;
    hit = (a[15:4] == r[15:4]);
    if (m3_n) begin
      hit = hit && (a[3] == r[3]);
    end
    if (m2_n) begin
      hit = hit && (a[2] == r[2]);
    end
    return hit;
  endfunction

  // ==========================================================
  // Configuration registers
  logic [7:0] control_reg, control_next;
  logic [7:0] prim_low_reg, prim_low_next;
  logic [7:0] prim_high_reg, prim_high_next;
  logic [5:0] sec_bits_reg, sec_bits_next;

  cycle_kind_s live_kind;
  logic setup_access;
  logic cmd_active;
  logic [15:2] primary_reloc_addr;
  logic [15:2] secondary_reloc_addr;
  logic secondary_reloc_disable;

  assign live_kind = decode_kind(host_status);
  assign cmd_active = !cmd_n;
  // Setup needs an IO read or write with setup low
  assign setup_access = !card_setup_n && (live_kind.io_read || live_kind.io_write);

  assign secondary_reloc_disable = control_reg[CTL_SEC_DIS_BIT];
  assign primary_reloc_addr = {prim_high_reg, prim_low_reg[7:2]};
  assign secondary_reloc_addr = {control_reg[CTL_SADR15_BIT], control_reg[CTL_SADR14_BIT],
                                 sec_bits_reg[5:4], primary_reloc_addr[11:9],
                                 prim_low_reg[1], sec_bits_reg[3:0], prim_low_reg[0],
                                 primary_reloc_addr[2]};

  always_comb begin
    control_next = control_reg;
    prim_low_next = prim_low_reg;
    prim_high_next = prim_high_reg;
    sec_bits_next = sec_bits_reg;
    // Write on the command edge would need edge logic; level write is idempotent
    if (clk_en && setup_access && live_kind.io_write && cmd_active) begin
      case (host_addr)
        OFF_CONTROL: control_next = data_in;
        OFF_PRIM_LOW: prim_low_next = data_in;
        OFF_PRIM_HIGH: prim_high_next = data_in;
        OFF_SEC_BITS: sec_bits_next = data_in[5:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      control_reg <= CONTROL_RESET;
      prim_low_reg <= ADDR_REG_RESET;
      prim_high_reg <= ADDR_REG_RESET;
      sec_bits_reg <= ADDR_REG_RESET[5:0];
    end else begin
      control_reg <= control_next;
      prim_low_reg <= prim_low_next;
      prim_high_reg <= prim_high_next;
      sec_bits_reg <= sec_bits_next;
    end
  end

  assign card_enable_output = control_reg[CTL_CARD_EN_BIT];
  assign config_outputs = control_reg[CTL_OUT_LSB +: 4];

  // ==========================================================
  // Read data path
  logic [7:0] rdata_reg, rdata_next;
  logic rd_oe_reg, rd_oe_next;

  always_comb begin
    rdata_next = rdata_reg;
    rd_oe_next = 1'b0;
    if (setup_access && live_kind.io_read && cmd_active) begin
      rd_oe_next = 1'b1;
      case (host_addr)
        OFF_ID_LOW, OFF_ID_HIGH: rdata_next = card_id_pins;
        OFF_CONTROL: rdata_next = control_reg;
        OFF_PRIM_LOW: rdata_next = prim_low_reg;
        OFF_PRIM_HIGH: rdata_next = prim_high_reg;
        OFF_SEC_BITS: rdata_next = {SEC_UNUSED_ONES, sec_bits_reg};
        default: rd_oe_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
      rd_oe_reg <= 1'b0;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
      rd_oe_reg <= rd_oe_next;
    end
  end

  assign data_out = rdata_reg;
  assign data_oe = rd_oe_reg;

  // ==========================================================
  // Cycle capture and address decode
  logic prim_hit, sec_hit;
  chan_status_s stat_reg, stat_next;
  logic prim_lat_reg, prim_lat_next;
  logic sec_lat_reg, sec_lat_next;
  logic in_cycle_reg, in_cycle_next;
  logic [3:0] addr_lat_reg, addr_lat_next;
  cycle_kind_s lat_kind;
  logic setup_cycle;
  logic id_low_sel, id_high_sel;

  assign prim_hit = !host_status.mem_io && reloc_match(host_addr, primary_reloc_addr,
                    compare_bypass_bit3_n, compare_bypass_bit2_n);
  assign sec_hit = !host_status.mem_io && !secondary_reloc_disable &&
                   reloc_match(host_addr, secondary_reloc_addr,
                   compare_bypass_bit3_n, compare_bypass_bit2_n);
  always_comb begin
    stat_next = stat_reg;
    prim_lat_next = prim_lat_reg;
    sec_lat_next = sec_lat_reg;
    in_cycle_next = in_cycle_reg;
    addr_lat_next = addr_lat_reg;
    if (!adl_n) begin
      addr_lat_next = host_addr[3:0];
    end
    // Capture at status start, release once command has ended and status is idle
    if (!in_cycle_reg && (host_status.s0 != host_status.s1)) begin
      stat_next = host_status;
      prim_lat_next = prim_hit && card_setup_n;
      sec_lat_next = sec_hit && card_setup_n;
      in_cycle_next = 1'b1;
    end else if (in_cycle_reg && cmd_n && (host_status.s0 == host_status.s1)) begin
      in_cycle_next = 1'b0;
      prim_lat_next = 1'b0;
      sec_lat_next = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stat_reg <= '{mem_io: 1'b1, s0: 1'b1, s1: 1'b1};
      prim_lat_reg <= 1'b0;
      sec_lat_reg <= 1'b0;
      in_cycle_reg <= 1'b0;
      addr_lat_reg <= 4'h0;
    end else if (clk_en) begin
      stat_reg <= stat_next;
      prim_lat_reg <= prim_lat_next;
      sec_lat_reg <= sec_lat_next;
      in_cycle_reg <= in_cycle_next;
      addr_lat_reg <= addr_lat_next;
    end
  end

  assign latched_addr = addr_lat_reg;
  assign lat_kind = decode_kind(stat_reg);
  assign setup_cycle = !card_setup_n;
  assign id_low_sel = setup_access && live_kind.io_read && (host_addr == OFF_ID_LOW);
  assign id_high_sel = setup_access && live_kind.io_read && (host_addr == OFF_ID_HIGH);

  // Shared pins: ID strobes in setup, chip selects otherwise
  assign id_low_strobe = setup_cycle ? id_low_sel
                                     : !(prim_hit || prim_lat_reg);
  assign id_high_strobe = setup_cycle ? id_high_sel
                                      : !((sec_hit || sec_lat_reg)
                                          && !secondary_reloc_disable);

  assign periph_read_strobe_n = !(!setup_cycle && (prim_lat_reg || sec_lat_reg)
                                  && lat_kind.io_read && cmd_active);
  assign periph_write_strobe_n = !(!setup_cycle && (prim_lat_reg || sec_lat_reg)
                                   && lat_kind.io_write && cmd_active);
  // Live decode gives the early feedback the host expects
  assign card_select_feedback_n = !(!setup_cycle && (prim_hit || sec_hit)
                                    && (host_status.s0 != host_status.s1));

  // Gated by command so a latched match never holds the data bus after the cycle
  assign buffer_enable_n = !(cmd_active && ((setup_access && host_addr >= OFF_ID_LOW
                              && host_addr <= OFF_SEC_BITS) ||
                             (!setup_cycle && (prim_lat_reg || sec_lat_reg))));
  assign buffer_direction_n = !(!buffer_enable_n &&
                                (setup_cycle ? live_kind.io_read
                                             : lat_kind.io_read));

  // ==========================================================
  // Channel ready generator
  rdy_state_e rdy_state_reg, rdy_state_next;
  logic [WAIT_CNT_W-1:0] wait_cnt_reg, wait_cnt_next;
  logic slow_rdy_reg, slow_rdy_next;
  wait_mode_e mode;
  logic matched;

  assign mode = wait_mode_e'({wait_select_hi, wait_select_lo});
  assign matched = !setup_cycle && (prim_lat_reg || sec_lat_reg);

  always_comb begin
    rdy_state_next = rdy_state_reg;
    wait_cnt_next = wait_cnt_reg;
    slow_rdy_next = slow_ready_input;
    case (rdy_state_reg)
      RDY_IDLE: begin
        if (matched) begin
          rdy_state_next = RDY_DECODED;
        end
      end
      RDY_DECODED: begin
        if (cmd_active) begin
          case (mode)
            MODE_SYNC_EXT: wait_cnt_next = WAIT_CNT_W'(SYNC_COUNT);
            MODE_WAIT1: wait_cnt_next = WAIT_CNT_W'(WS1_COUNT);
            MODE_WAIT2: wait_cnt_next = WAIT_CNT_W'(WS2_COUNT);
            default: wait_cnt_next = '0;
          endcase
          rdy_state_next = (mode == MODE_ASYNC_EXT) ? RDY_WAIT_SLOW : RDY_COUNT;
        end else if (!matched) begin
          rdy_state_next = RDY_IDLE;
        end
      end
      RDY_COUNT: begin
        wait_cnt_next = wait_cnt_reg - WAIT_CNT_W'(1);
        if (wait_cnt_reg <= WAIT_CNT_W'(1)) begin
          rdy_state_next = RDY_DONE;
        end
      end
      RDY_WAIT_SLOW: begin
        // Slow peripheral bounds this wait
        if (slow_ready_input && !slow_rdy_reg) begin
          rdy_state_next = RDY_DONE;
        end else if (!matched) begin
          // Abandoned cycle must not leave ready stuck low
          rdy_state_next = RDY_IDLE;
        end
      end
      RDY_DONE: begin
        if (!matched) begin
          rdy_state_next = RDY_IDLE;
        end
      end
      default: rdy_state_next = RDY_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdy_state_reg <= RDY_IDLE;
      wait_cnt_reg <= '0;
      slow_rdy_reg <= 1'b0;
    end else if (clk_en) begin
      rdy_state_reg <= rdy_state_next;
      wait_cnt_reg <= wait_cnt_next;
      slow_rdy_reg <= slow_rdy_next;
    end
  end

  // Setup never stretches
  assign channel_ready_out = setup_cycle ||
                             !(rdy_state_reg == RDY_DECODED || rdy_state_reg == RDY_COUNT ||
                               rdy_state_reg == RDY_WAIT_SLOW);

endmodule // channel_io_slave_adapter
`default_nettype wire

// ==== dv/chan_adapter_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module chan_adapter_assertions
  import chan_adapter_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [15:0] host_addr,
  input wire chan_status_s host_status,
  input wire logic cmd_n,
  input wire logic card_setup_n,
  input wire logic [7:0] data_in,
  input wire logic wait_select_hi,
  input wire logic wait_select_lo,
  input wire logic slow_ready_input,
  input wire logic id_low_strobe,
  input wire logic id_high_strobe,
  input wire logic card_enable_output,
  input wire logic [3:0] config_outputs,
  input wire logic periph_read_strobe_n,
  input wire logic periph_write_strobe_n,
  input wire logic card_select_feedback_n,
  input wire logic channel_ready_out,
  input wire logic buffer_enable_n,
  input wire logic buffer_direction_n
);
  logic io_rd, io_wr, sc, w;
  logic [1:0] mode;
  assign io_rd = !host_status.mem_io && host_status.s0 && !host_status.s1;
  assign io_wr = !host_status.mem_io && !host_status.s0 && host_status.s1;
  assign sc = !card_setup_n && !cmd_n && clk_en;
  assign w = sc && io_wr && host_addr == OFF_CONTROL;
  assign mode = {wait_select_hi, wait_select_lo};
  // ==========================================================
  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  AST_SETUP_READY: assert property (!card_setup_n |-> channel_ready_out)
    else $error("ready low in setup");
  AST_SETUP_NO_FBK: assert property (!card_setup_n |-> card_select_feedback_n)
    else $error("feedback in setup");
  AST_ID_LOW: assert property (sc && io_rd && host_addr == OFF_ID_LOW |-> id_low_strobe)
    else $error("low id strobe idle");
  AST_ID_HIGH: assert property (sc && io_rd && host_addr == OFF_ID_HIGH
    |-> id_high_strobe) else $error("high id strobe idle");
  AST_CTL_OUT: assert property (w ##1 w |-> ##1
    {config_outputs, card_enable_output} == $past(data_in[4:0])) else $error("control outputs");
  AST_STROBE_CMD: assert property (
    !(periph_read_strobe_n && periph_write_strobe_n) |-> !cmd_n && card_setup_n)
    else $error("strobe without command");
  AST_DIR_READ: assert property (!buffer_direction_n |-> !buffer_enable_n && io_rd)
    else $error("direction without read");
  AST_RESET_CTL: assert property ($rose(rstn)
    |-> {config_outputs, card_enable_output} == 5'h00) else $error("control not cleared");
  AST_SYNC: assert property ($fell(cmd_n) && !channel_ready_out && mode == 2'h0
    |-> ##[1:3] channel_ready_out) else $error("sync release late");
  AST_WAIT1: assert property ($fell(cmd_n) && !channel_ready_out && mode == 2'h1 |=>
    !channel_ready_out[*8] ##2 !channel_ready_out ##[1:5] channel_ready_out)
    else $error("wait 1 interval");
  AST_WAIT2: assert property ($fell(cmd_n) && !channel_ready_out && mode == 2'h2 |=>
    !channel_ready_out[*8] ##13 !channel_ready_out ##[1:5] channel_ready_out)
    else $error("wait 2 interval");
  AST_ASYNC: assert property (mode == 2'h3 && !channel_ready_out && !slow_ready_input
    |=> !channel_ready_out) else $error("async early release");
endmodule // chan_adapter_assertions
bind channel_io_slave_adapter chan_adapter_assertions chk (.mclk, .rstn, .clk_en, .host_addr,
  .host_status, .cmd_n, .card_setup_n, .data_in, .wait_select_hi, .wait_select_lo,
  .slow_ready_input, .id_low_strobe, .id_high_strobe, .card_enable_output, .config_outputs,
  .periph_read_strobe_n, .periph_write_strobe_n, .card_select_feedback_n, .channel_ready_out,
  .buffer_enable_n, .buffer_direction_n);
`default_nettype wire

// ==== dv/slow_periph_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module slow_periph_model #(
  parameter int DLY = 6,
  // Arbitrary card id bytes
  parameter logic [7:0] ID_LO = 8'hA5,
  parameter logic [7:0] ID_HI = 8'h3C
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic id_low_strobe,
  input wire logic id_high_strobe,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic slow_ready,
  output logic [7:0] id_pins
);
  int cnt;
  // Pins tied high, low or to a strobe, per bit
  assign id_pins = (ID_LO & ID_HI) | (ID_LO & ~ID_HI & {8{id_low_strobe}})
    | (~ID_LO & ID_HI & {8{id_high_strobe}});
  // Rises well inside 3 us, drops with the strobe
  assign slow_ready = (cnt == DLY);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) cnt <= 0;
    else if (rd_n && wr_n) cnt <= 0;
    else if (cnt < DLY) cnt <= cnt + 1;
  end
endmodule // slow_periph_model
`default_nettype wire

// ==== dv/channel_io_slave_adapter_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module channel_io_slave_adapter_tb
  import chan_adapter_pkg::*;
;
  logic mclk, rstn, clk_en, cmd_n, adl_n, card_setup_n, wait_select_hi, wait_select_lo, oe;
  logic compare_bypass_bit2_n, compare_bypass_bit3_n, slow_ready_input, data_oe;
  logic id_low_strobe, id_high_strobe, card_enable_output, channel_ready_out;
  logic periph_read_strobe_n, periph_write_strobe_n, card_select_feedback_n;
  logic buffer_enable_n, buffer_direction_n;
  logic [15:0] host_addr;
  logic [7:0] data_in, data_out, card_id_pins, q;
  logic [3:0] config_outputs, latched_addr;
  chan_status_s host_status;
  int fails, samples_checked, cyc, n;
  int lo[4] = '{1, 11, 21, 7};
  int hi[4] = '{3, 14, 25, 12};
  channel_io_slave_adapter uut (.mclk, .rstn, .clk_en, .host_addr, .host_status, .cmd_n,
    .adl_n, .card_setup_n, .data_in, .data_out, .data_oe, .card_id_pins, .compare_bypass_bit2_n,
    .compare_bypass_bit3_n, .wait_select_hi, .wait_select_lo, .slow_ready_input, .id_low_strobe,
    .id_high_strobe, .latched_addr, .card_enable_output, .config_outputs, .periph_read_strobe_n,
    .periph_write_strobe_n, .card_select_feedback_n, .channel_ready_out, .buffer_enable_n,
    .buffer_direction_n);
  slow_periph_model peer (.mclk, .rstn, .id_low_strobe, .id_high_strobe,
    .rd_n(periph_read_strobe_n), .wr_n(periph_write_strobe_n), .slow_ready(slow_ready_input),
    .id_pins(card_id_pins));
  // ==========================================================
  // Tasks
  task tick; @(posedge mclk); #1; endtask
  task close_out;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task cfg(input logic wr, input logic [15:0] a, input logic [7:0] d);
    host_status = {1'b0, !wr, wr}; host_addr = a; data_in = d;
    card_setup_n = 0; cmd_n = 0; adl_n = 0;
    repeat (3) tick;
    q = data_out; oe = data_oe;
    cmd_n = 1; adl_n = 1; host_status = 3'h3; card_setup_n = 1;
    tick;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    cfg(0, a, 8'h00);
    `CHK({oe, q}, {1'b1, e})
  endtask
  // Select lines are {primary, secondary}
  task io(input logic wr, input logic [15:0] a, input logic [1:0] m, input logic [1:0] sel);
    {wait_select_hi, wait_select_lo} = m;
    host_status = {1'b0, !wr, wr}; host_addr = a; adl_n = 0;
    tick; adl_n = 1; tick;
    `CHK(latched_addr, a[3:0])
    `CHK({id_low_strobe, id_high_strobe}, ~sel)
    `CHK(channel_ready_out, !(|sel))
    cmd_n = 0; tick;
    `CHK({periph_read_strobe_n, periph_write_strobe_n}, (|sel) ? {wr, !wr} : 2'h3)
    `CHK(card_select_feedback_n, !(|sel))
    `CHK({buffer_enable_n, buffer_direction_n}, (|sel) ? {1'b0, wr} : 2'h3)
    n = 1;
    while (!channel_ready_out && n < 60) begin tick; n++; end
    cmd_n = 1; host_status = 3'h3; repeat (2) tick;
  endtask
  // ==========================================================
  // Clock, timeout, sequence
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin fails++; close_out; end
  end
  initial begin
    rstn = 0; cmd_n = 1; adl_n = 1; card_setup_n = 1; host_status = 3'h3; host_addr = 16'h0000;
    clk_en = 1;
    data_in = 8'h00; wait_select_hi = 0; wait_select_lo = 0;
    compare_bypass_bit2_n = 1; compare_bypass_bit3_n = 1;
    repeat (6) @(posedge mclk);
    #1 rstn = 1; tick;
    rd(OFF_CONTROL, CONTROL_RESET);
    rd(OFF_ID_LOW, 8'hA5);
    rd(OFF_ID_HIGH, 8'h3C);
    cfg(0, 16'h0106, 8'h00); `CHK(oe, 1'b0)
    cfg(1, OFF_ID_LOW, 8'hC3); rd(OFF_ID_LOW, 8'hA5);
    cfg(1, OFF_CONTROL, 8'h1F);
    `CHK({config_outputs, card_enable_output}, 5'h1F)
    clk_en = 0; cfg(1, OFF_CONTROL, 8'h00); clk_en = 1;
    `CHK({config_outputs, card_enable_output}, 5'h1F)
    io(1, OFF_CONTROL, 2'h0, 2'h0); rd(OFF_CONTROL, 8'h1F);
    cfg(1, OFF_SEC_BITS, 8'h00); rd(OFF_SEC_BITS, 8'hC0);
    cfg(1, OFF_PRIM_HIGH, 8'h12); cfg(1, OFF_PRIM_LOW, 8'h30);
    rd(OFF_PRIM_LOW, 8'h30); rd(OFF_PRIM_HIGH, 8'h12);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      io(m[0], 16'h1231, m[1:0], 2'h2);
      `CHK((n >= lo[m]) && (n <= hi[m]), 1'b1)
    end
    $display("test wait modes done");
    io(0, 16'h1234, 2'h0, 2'h0);
    compare_bypass_bit2_n = 0; io(0, 16'h1234, 2'h0, 2'h2);
    compare_bypass_bit2_n = 1; compare_bypass_bit3_n = 0;
    io(0, 16'h1238, 2'h0, 2'h2); compare_bypass_bit3_n = 1;
    io(0, 16'h0200, 2'h0, 2'h1);
    cfg(1, OFF_CONTROL, 8'h3F); io(0, 16'h0200, 2'h0, 2'h0);
    host_status = 3'h5; host_addr = 16'h1231; repeat (2) tick;
    `CHK({id_low_strobe, card_select_feedback_n, channel_ready_out}, 3'h7)
    host_status = 3'h3; repeat (2) tick;
    $display("test relocation done");
    close_out;
  end
endmodule // channel_io_slave_adapter_tb
`default_nettype wire
